//--- rtl/upc_core.v
// Purpose: control core of a usb peripheral, serial slave port and axi4-lite port
// Assumes: usb side strobes on aclk, serial pins and comparator asynchronous
// Notes: buffer memory in flip-flops, full-duplex serial port only
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "upc_defines.vh"
module upc_core #(
  parameter AW = 8,
  parameter [17:0] WAKE_CYC = `UPC_WAKE_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire chip_reset_n,
  input wire spi_sclk,
  input wire spi_ss_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  input wire vbus_sense_input,
  output reg pullup_attach,
  output reg osc_enable,
  output reg host_interrupt_out,
  input wire [1:0] usb_ep,
  input wire usb_wr,
  input wire [7:0] usb_wdata,
  input wire usb_rd,
  output reg [7:0] usb_rdata,
  input wire usb_pkt_rx,
  input wire usb_pkt_tx,
  input wire usb_suspend,
  input wire usb_resume
);
  localparam OSC_RUN = 2'h0;
  localparam OSC_OFF = 2'h1;
  localparam OSC_WAKE = 2'h2;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire sclk_s, ss_s, mosi_s, vbus_present, crst_n_s;
  upc_sync2 #(.RST_VAL(1'b0)) u_sclk (.aclk(aclk), .aresetn(aresetn), .d(spi_sclk), .q(sclk_s));
  upc_sync2 #(.RST_VAL(1'b1)) u_ss (.aclk(aclk), .aresetn(aresetn), .d(spi_ss_n), .q(ss_s));
  upc_sync2 #(.RST_VAL(1'b0)) u_mosi (.aclk(aclk), .aresetn(aresetn), .d(spi_mosi), .q(mosi_s));
  upc_sync2 #(.RST_VAL(1'b0)) u_vbus (.aclk(aclk), .aresetn(aresetn), .d(vbus_sense_input),
    .q(vbus_present));
  upc_sync2 #(.RST_VAL(1'b0)) u_crst (.aclk(aclk), .aresetn(aresetn), .d(chip_reset_n), .q(crst_n_s));

  wire core_rst = ~aresetn | ~crst_n_s;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] mem [0:`UPC_MEM_BYTES-1];
  reg [5:0] cptr [0:3];
  reg [5:0] uptr [0:3];
  reg [3:0] csel, usel;
  reg [7:0] usb_ctl, cpu_ctl, flags;
  reg [1:0] osc_st;
  reg [17:0] osc_cnt;
  reg osc_ok, osc_rdy_p, vbus_d, sclk_d, ss_d;
  reg [2:0] spi_bits;
  reg [7:0] spi_rx, spi_tx, spi_cmd;
  reg spi_cmd_ok, spi_data;
  reg [AW-1:0] aw_q;
  reg [7:0] w_q;
  reg aw_hold, w_hold, w_en;
  integer i;

  // buffer index of an endpoint, a buffer half and a byte pointer
  function [8:0] ep_idx;
    input [1:0] ep;
    input sel;
    input [5:0] p;
    reg [8:0] b;
    begin
      case (ep)
        2'h0: b = `UPC_EP0_BASE;
        2'h1: b = `UPC_EP1_BASE;
        2'h2: b = `UPC_EP2_BASE;
        default: b = `UPC_EP3_BASE;
      endcase
      ep_idx = b + {2'h0, sel, p};
    end
  endfunction

  // ----------------------------------------
  // serial port decode
  // ----------------------------------------
  wire s_rise = sclk_s & ~sclk_d & ~ss_s;
  wire s_fall = ~sclk_s & sclk_d & ~ss_s;
  wire byte_done = s_rise & (spi_bits == 3'h7);
  wire [7:0] spi_byte = {spi_rx[6:0], mosi_s};
  wire [7:0] cmd_now = spi_cmd_ok ? spi_cmd : spi_byte;
  wire [2:0] cur_a = cmd_now[`UPC_CMD_AHI:`UPC_CMD_ALO];
  wire cur_wr = cmd_now[`UPC_CMD_WR];
  wire [1:0] cur_ep = cur_a[1:0];
  wire cur_fifo = ~cur_a[2];
  wire spi_wr = byte_done & spi_cmd_ok & cur_wr;
  wire spi_rd = byte_done & ~cur_wr;
  wire fifo_step = (spi_wr | spi_rd) & cur_fifo;
  wire [8:0] c_idx = ep_idx(cur_ep, csel[cur_ep], cptr[cur_ep]);
  wire [8:0] u_idx = ep_idx(usb_ep, usel[usb_ep], uptr[usb_ep]);
  wire [7:0] status = {3'h0, pullup_attach, csel[2], csel[1], osc_ok, vbus_present};

  // ----------------------------------------
  // axi4-lite decode
  // ----------------------------------------
  wire aw_hit = (aw_q[AW-1:5] == 0) & aw_q[4];
  wire ar_hit = (s_axi_araddr[AW-1:5] == 0) & s_axi_araddr[4];
  wire axi_do = aw_hold & w_hold & ~s_axi_bvalid;
  wire axi_we = axi_do & aw_hit & w_en;
  assign s_axi_awready = ~aw_hold;
  assign s_axi_wready = ~w_hold;
  assign s_axi_arready = ~s_axi_rvalid;

  // one register write port, axi first
  wire reg_we = axi_we | (spi_wr & ~cur_fifo & ~axi_we);
  wire [2:0] reg_a = axi_we ? {1'b1, aw_q[3:2]} : cur_a;
  wire [7:0] reg_d = axi_we ? w_q : spi_byte;

  // register read mux for both ports
  function [7:0] reg_rd;
    input [2:0] a;
    begin
      if (a == `UPC_A_IRQ) begin
        reg_rd = flags;
      end else if (a == `UPC_A_CPU) begin
        reg_rd = cpu_ctl;
      end else if (a == `UPC_A_USB) begin
        reg_rd = usb_ctl;
      end else begin
        reg_rd = status;
      end
    end
  endfunction

  // ----------------------------------------
  // axi slave
  // ----------------------------------------
  // address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= {AW{1'b0}};
      w_q <= 8'h00;
      w_en <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UPC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `UPC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid & ~aw_hold) begin
        aw_hold <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_hold) begin
        w_hold <= 1'b1;
        w_q <= s_axi_wdata[7:0];
        w_en <= s_axi_wstrb[0];
      end
      if (axi_do) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_hit ? `UPC_RESP_OKAY : `UPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & ~s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ar_hit ? `UPC_RESP_OKAY : `UPC_RESP_SLVERR;
        s_axi_rdata <= ar_hit ? {24'h000000, reg_rd({1'b1, s_axi_araddr[3:2]})} : 32'h00000000;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // usb control survives chip reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      usb_ctl <= `UPC_REG_RST;
    end else if (reg_we & (reg_a == `UPC_A_USB)) begin
      usb_ctl <= reg_d;
    end
  end

  // cpu control and flags; a set beats a clear
  always @(posedge aclk) begin
    if (core_rst) begin
      cpu_ctl <= `UPC_REG_RST;
      flags <= `UPC_REG_RST;
    end else begin
      if (reg_we & (reg_a == `UPC_A_CPU)) begin
        cpu_ctl <= reg_d;
      end
      flags <= (flags & ~((reg_we & (reg_a == `UPC_A_IRQ)) ? reg_d : 8'h00)) |
        {2'h0, osc_rdy_p, vbus_d & ~vbus_present, usb_resume, usb_suspend, usb_pkt_tx, usb_pkt_rx};
    end
  end

  // ----------------------------------------
  // outputs: pull-up and interrupt
  // ----------------------------------------
  always @(posedge aclk) begin
    if (core_rst) begin
      host_interrupt_out <= 1'b0;
      vbus_d <= 1'b0;
    end else begin
      host_interrupt_out <= cpu_ctl[`UPC_CPU_IE] & (|flags);
      vbus_d <= vbus_present;
    end
  end

  // pull-up from usb control and vbus only, so chip reset keeps it
  always @(posedge aclk) begin
    if (!aresetn) begin
      pullup_attach <= 1'b0;
    end else begin
      pullup_attach <= usb_ctl[`UPC_USB_CONN] & (~usb_ctl[`UPC_USB_GATE] | vbus_present);
    end
  end

  // ----------------------------------------
  // oscillator control
  // ----------------------------------------
  always @(posedge aclk) begin
    if (core_rst) begin
      osc_st <= OSC_RUN;
      osc_cnt <= 18'h00000;
      osc_enable <= 1'b1;
      osc_ok <= 1'b1;
      osc_rdy_p <= 1'b0;
    end else begin
      osc_rdy_p <= 1'b0;
      case (osc_st)
        OSC_RUN: begin
          if (cpu_ctl[`UPC_CPU_PD]) begin
            osc_enable <= 1'b0;
            osc_ok <= 1'b0;
            osc_st <= OSC_OFF;
          end
        end
        OSC_OFF: begin
          if (!cpu_ctl[`UPC_CPU_PD]) begin
            osc_enable <= 1'b1;
            osc_cnt <= 18'h00000;
            osc_st <= OSC_WAKE;
          end
        end
        OSC_WAKE: begin
          if (cpu_ctl[`UPC_CPU_PD]) begin
            osc_enable <= 1'b0;
            osc_st <= OSC_OFF;
          end else if (osc_cnt == WAKE_CYC - 18'h00001) begin
            osc_ok <= 1'b1;
            osc_rdy_p <= 1'b1;
            osc_st <= OSC_RUN;
          end else begin
            osc_cnt <= osc_cnt + 18'h00001;
          end
        end
        default: begin
          osc_st <= OSC_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // serial engine, not touched by chip reset
  // ----------------------------------------
  // sampled on rising sclk, shifted out on falling sclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d <= 1'b0;
      ss_d <= 1'b1;
      spi_bits <= 3'h0;
      spi_rx <= 8'h00;
      spi_tx <= 8'h00;
      spi_cmd <= 8'h00;
      spi_cmd_ok <= 1'b0;
      spi_data <= 1'b0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      ss_d <= ss_s;
      if (ss_s) begin
        spi_bits <= 3'h0; // partial byte dropped
        spi_cmd_ok <= 1'b0;
        spi_miso_oe <= 1'b0;
      end else if (ss_d) begin
        spi_tx <= flags; // interrupt flags during the command byte
        spi_miso <= flags[7];
        spi_miso_oe <= 1'b1;
        spi_data <= 1'b0;
      end else if (s_rise) begin
        spi_bits <= spi_bits + 3'h1;
        spi_rx <= spi_byte;
        spi_tx <= {spi_tx[6:0], 1'b0};
        if (byte_done) begin
          spi_cmd_ok <= 1'b1;
          spi_data <= spi_data | spi_cmd_ok;
          if (!spi_cmd_ok) begin
            spi_cmd <= spi_byte;
          end
          if (!cur_wr) begin
            spi_tx <= cur_fifo ? mem[c_idx] : reg_rd(cur_a);
          end else begin
            spi_tx <= 8'h00;
          end
        end
      end else if (s_fall) begin
        spi_miso <= spi_tx[7];
      end
    end
  end

  // ----------------------------------------
  // buffer pointers and halves
  // ----------------------------------------
  // endpoints act the same whatever the transfer type
  always @(posedge aclk) begin
    if (core_rst) begin
      csel <= 4'h0;
      usel <= 4'h0;
      usb_rdata <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        cptr[i] <= 6'h00;
        uptr[i] <= 6'h00;
      end
    end else begin
      if (fifo_step) begin
        cptr[cur_ep] <= cptr[cur_ep] + 6'h01;
      end else if (ss_s & ~ss_d & spi_data & ~spi_cmd[`UPC_CMD_AHI]) begin
        cptr[spi_cmd[`UPC_CMD_ALO+1:`UPC_CMD_ALO]] <= 6'h00;
        if ((spi_cmd[`UPC_CMD_ALO+1:`UPC_CMD_ALO] == 2'h1) | (spi_cmd[`UPC_CMD_ALO+1:`UPC_CMD_ALO] == 2'h2)) begin
          csel[spi_cmd[`UPC_CMD_ALO+1:`UPC_CMD_ALO]] <= ~csel[spi_cmd[`UPC_CMD_ALO+1:`UPC_CMD_ALO]];
        end
      end
      if (usb_rd) begin
        usb_rdata <= mem[u_idx];
      end
      if (usb_pkt_rx | usb_pkt_tx) begin
        uptr[usb_ep] <= 6'h00;
        if ((usb_ep == 2'h1) | (usb_ep == 2'h2)) begin
          usel[usb_ep] <= ~usel[usb_ep];
        end
      end else if (usb_rd | usb_wr) begin
        uptr[usb_ep] <= uptr[usb_ep] + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // buffer memory, two write ports
  // ----------------------------------------
  always @(posedge aclk) begin
    if (usb_wr) begin
      mem[u_idx] <= usb_wdata;
    end
    if (spi_wr & cur_fifo) begin
      mem[c_idx] <= spi_byte;
    end
  end
endmodule

//--- rtl/upc_defines.vh
// Purpose: constants of the usb peripheral core control block
// Assumes: 50 MHz core clock, byte-wide registers, full-duplex serial port
// Notes: included by the core and the testbench, not by the synchroniser
`ifndef UPC_DEFINES_VH
`define UPC_DEFINES_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define UPC_A_EP0 3'h0
`define UPC_A_EP1 3'h1
`define UPC_A_EP2 3'h2
`define UPC_A_EP3 3'h3
`define UPC_A_IRQ 3'h4
`define UPC_A_CPU 3'h5
`define UPC_A_USB 3'h6
`define UPC_A_STAT 3'h7

// ----------------------------------------
// fields
// ----------------------------------------
`define UPC_CMD_AHI 5
`define UPC_CMD_ALO 3
`define UPC_CMD_WR 1
`define UPC_USB_CONN 0
`define UPC_USB_GATE 1
`define UPC_CPU_IE 0
`define UPC_CPU_PD 1
`define UPC_F_RX 0
`define UPC_F_TX 1
`define UPC_F_SUSP 2
`define UPC_F_RES 3
`define UPC_F_VBL 4
`define UPC_F_OSC 5
`define UPC_REG_RST 8'h00

// ----------------------------------------
// memory layout
// ----------------------------------------
`define UPC_MEM_BYTES 384
`define UPC_EP0_BASE 9'h000
`define UPC_EP1_BASE 9'h040
`define UPC_EP2_BASE 9'h0c0
`define UPC_EP3_BASE 9'h140

// ----------------------------------------
// timing and axi response codes
// ----------------------------------------
`define UPC_CLK_MHZ 50
`define UPC_WAKE_US 3000
`define UPC_WAKE_CYC (`UPC_WAKE_US * `UPC_CLK_MHZ)
`define UPC_RESP_OKAY 2'h0
`define UPC_RESP_SLVERR 2'h2

`endif

//--- rtl/upc_sync2.v
// Purpose: two flip-flop synchroniser for one level
// Assumes: input asynchronous to aclk
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
module upc_sync2 #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire aclk,
  input wire aresetn,
  input wire d,
  output reg q
);
  reg meta;

  // two stages, constant reset value
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

//--- sim/upc_core_sva.sv
// Purpose: port assertions of the usb peripheral core control block
// Assumes: one clock domain aclk, synchronous reset aresetn
// Notes: bound into every upc_core instance
`timescale 1ns/1ps
module upc_core_sva #(
  parameter AW = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire chip_reset_n,
  input wire spi_ss_n,
  input wire spi_miso_oe,
  input wire osc_enable,
  input wire host_interrupt_out
);
  // ----------------------------------------
  // write taken on both channels at once
  // ----------------------------------------
  wire aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_b_lat: assert property (aw_go |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_bad_addr: assert property (aw_go && (s_axi_awaddr < 8'h10 || s_axi_awaddr > 8'h1f) |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  chk_miso_idle: assert property (spi_ss_n [*4] |-> !spi_miso_oe)
    else $error("serial output driven while deselected");
  chk_pd_stop: assert property (aw_go && s_axi_awaddr == 8'h14 && s_axi_wdata[1] && s_axi_wstrb[0]
    |-> ##[1:250] !osc_enable)
    else $error("oscillator not stopped in time");
  chk_int_reset: assert property (!chip_reset_n [*6] |-> !host_interrupt_out)
    else $error("interrupt active in chip reset");
  // main scenarios reached
  cover property (aw_go && s_axi_awaddr < 8'h10);
  cover property ($rose(host_interrupt_out));
  cover property (!osc_enable);
endmodule
bind upc_core upc_core_sva #(.AW(AW)) u_sva (.*);

//--- sim/upc_spi_host.sv
// Purpose: serial port master in front of the core
// Assumes: 160 ns serial clock, modes (0,0) and (1,1)
// Notes: data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
module upc_spi_host (
  output reg spi_sclk,
  output reg spi_ss_n,
  output reg spi_mosi,
  input wire spi_miso
);
  reg cpol;
  // ----------------------------------------
  // frame tasks
  // ----------------------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
    cpol = 1'b0;
  end
  // idle clock level chosen by mode, no mode setting in the core
  task frame_on(input m);
    begin
      cpol = m;
      spi_sclk = m;
      #100 spi_ss_n = 1'b0;
      #200;
    end
  endtask
  // one byte, msb first, sampled on the rising edge
  task xb(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        spi_sclk = 1'b0;
        spi_mosi = tx[i];
        #80 spi_sclk = 1'b1;
        rx[i] = spi_miso;
        #80;
      end
      if (!cpol) spi_sclk = 1'b0;
    end
  endtask
  // release line, hold deselect long enough
  task frame_off;
    begin
      #200 spi_ss_n = 1'b1;
      spi_mosi = ~spi_mosi;
      spi_sclk = cpol;
      #300;
    end
  endtask
endmodule

//--- sim/testbench.sv
// Purpose: self-checking bench of the usb peripheral core control block
// Assumes: 50 MHz aclk, wake count shortened to 20
// Notes: registers over axi4-lite, serial frames through upc_spi_host
`timescale 1ns/1ps
`include "upc_defines.vh"
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin fails = fails + 1; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam WAKE = 20;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr, usb_wdata, b;
  reg [31:0] s_axi_wdata, d;
  reg [3:0] s_axi_wstrb;
  reg chip_reset_n, vbus_sense_input, usb_wr, usb_rd, usb_pkt_rx, usb_pkt_tx, usb_suspend, usb_resume;
  reg [1:0] usb_ep, r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe, pullup_attach, osc_enable, host_interrupt_out;
  wire [7:0] usb_rdata;
  integer fails, n_checks, i;
  upc_core #(.AW(8), .WAKE_CYC(WAKE)) DUT (.*);
  upc_spi_host m (.*);
  // ----------------------------------------
  // clock, bus tasks, verdict
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // axi write, both channels offered together
  task wr(input [7:0] a, input [31:0] v, output [1:0] rsp);
    reg ta, tw;
    begin
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'b111};
      ta = 0;
      tw = 0;
      while (!(ta && tw)) begin
        @(posedge aclk);
        if (!ta && s_axi_awready) begin ta = 1; s_axi_awvalid <= 1'b0; end
        if (!tw && s_axi_wready) begin tw = 1; s_axi_wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v, output [1:0] rsp);
    begin
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // usb side strobes
  task ustb(input [1:0] ep, input [7:0] v, input w, input [3:0] ev);
    begin
      @(posedge aclk);
      {usb_ep, usb_wdata, usb_wr, usb_rd} <= {ep, v, w, ~w & ~|ev};
      {usb_resume, usb_suspend, usb_pkt_tx, usb_pkt_rx} <= ev;
      @(posedge aclk);
      {usb_wr, usb_rd, usb_resume, usb_suspend, usb_pkt_tx, usb_pkt_rx} <= 6'h00;
      @(posedge aclk);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {fails, n_checks} = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, usb_wdata, usb_ep} = 0;
    {usb_wr, usb_rd, usb_pkt_rx, usb_pkt_tx, usb_suspend, usb_resume} = 6'h00;
    {chip_reset_n, vbus_sense_input, s_axi_wstrb} = 6'h3f;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h14, d, r); `CHK(d, 32'h0)
    rd(8'h18, d, r); `CHK(d, 32'h0)
    rd(8'h00, d, r); `CHK({r, d}, {`UPC_RESP_SLVERR, 32'h0})
    wr(8'h20, 32'h1, r); `CHK(r, `UPC_RESP_SLVERR)
    wr(8'h00, 32'h1, r); `CHK(r, `UPC_RESP_SLVERR)
    $display("test map done");
    for (i = 0; i < 8; i = i + 1) begin
      vbus_sense_input <= i[2];
      wr(8'h18, i & 3, r);
      repeat (6) @(posedge aclk);
      `CHK(pullup_attach, i[0] & (!i[1] | i[2]))
    end
    wr(8'h10, 32'hff, r);
    vbus_sense_input <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(8'h10, d, r); `CHK(d[`UPC_F_VBL], 1'b1)
    rd(8'h1c, d, r); `CHK({d[4], d[0]}, 2'b00)
    wr(8'h10, 32'hff, r);
    rd(8'h10, d, r); `CHK(d, 32'h0)
    vbus_sense_input <= 1'b1;
    $display("test pullup done");
    for (i = 0; i < 4; i = i + 1) begin
      ustb(2'd0, 8'h00, 1'b0, 4'h1 << i);
      rd(8'h10, d, r); `CHK(d[i], 1'b1)
      `CHK(host_interrupt_out, 1'b0)
    end
    wr(8'h14, 32'h1, r);
    repeat (2) @(posedge aclk);
    `CHK(host_interrupt_out, 1'b1)
    wr(8'h14, 32'h0, r);
    repeat (2) @(posedge aclk);
    `CHK(host_interrupt_out, 1'b0)
    wr(8'h10, 32'hff, r);
    wr(8'h14, 32'h2, r);
    repeat (4) @(posedge aclk);
    `CHK(osc_enable, 1'b0)
    wr(8'h14, 32'h0, r);
    repeat (WAKE + 10) @(posedge aclk);
    rd(8'h10, d, r); `CHK(d[`UPC_F_OSC], 1'b1)
    rd(8'h1c, d, r); `CHK({osc_enable, d[1]}, 2'b11)
    $display("test events done");
    m.frame_on(1'b0);
    m.xb(8'h02, b); `CHK(b, 8'h20)
    m.xb(8'ha5, b);
    m.xb(8'h3c, b); `CHK(b, 8'h00)
    m.frame_off;
    ustb(2'd0, 8'h00, 1'b0, 4'h0); `CHK(usb_rdata, 8'ha5)
    ustb(2'd0, 8'h00, 1'b0, 4'h0); `CHK(usb_rdata, 8'h3c)
    ustb(2'd3, 8'h5a, 1'b1, 4'h0);
    ustb(2'd3, 8'hc3, 1'b1, 4'h0);
    m.frame_on(1'b1);
    m.xb(8'h18, b);
    m.xb(8'h00, b); `CHK(b, 8'h5a)
    m.xb(8'h00, b); `CHK(b, 8'hc3)
    m.frame_off;
    m.frame_on(1'b1);
    m.xb(8'h30, b);
    m.xb(8'h00, b); `CHK(b, 8'h03)
    m.frame_off;
    rd(8'h1c, d, r); `CHK(d[3], 1'b0)
    m.frame_on(1'b0);
    m.xb(8'h12, b);
    m.xb(8'h77, b);
    m.frame_off;
    repeat (6) @(posedge aclk);
    rd(8'h1c, d, r); `CHK(d[3], 1'b1)
    $display("test serial done");
    wr(8'h14, 32'h1, r);
    chip_reset_n <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK(host_interrupt_out, 1'b0)
    chip_reset_n <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(8'h18, d, r); `CHK(d, 32'h3)
    rd(8'h14, d, r); `CHK(d, 32'h0)
    `CHK(pullup_attach, 1'b1)
    $display("test chip reset done");
    wrap_up;
  end
  // tests take about 23 us, allow ample margin
  initial begin
    #500000;
    fails = fails + 1;
    wrap_up;
  end
endmodule
